// ### shared/pmla_pkg.sv
// Package of constants for the power monitor limit and alert block
package pmla_pkg;
  // Result and limit widths
  localparam int RES_W   = 16;
  localparam int PWR_W   = 24;
  localparam int LIM_W   = 16;
  localparam int PWR_SHIFT = 8;   // One power limit code weighs 256 power codes
  // Fixed-point result weights, physical value = code times weight
  localparam int CUR_LSB_NA   = 1200000;  // 1.2 mA in nA
  localparam int VBUS_LSB_NV  = 3125000;  // 3.125 mV in nV
  localparam int PWR_LSB_NW   = 240000;   // 240 uW in nW
  localparam int ENG_LSB_UJ   = 3840;     // 3.84 mJ in uJ
  localparam int CHG_LSB_NC   = 75000;    // 75 uC in nC
  localparam int TEMP_LSB_UC  = 125000;   // 125 m degC in micro degC
  // Timing
  localparam int CLK_MHZ        = 250;
  localparam int CONV_TIME_US   = 50;
  localparam int MATH_TIME_US   = 25;
  localparam int CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
  localparam int MATH_CYCLES    = MATH_TIME_US * CLK_MHZ;
  localparam int CNT_W          = 16;
  // Reset values of thresholds and enables
  localparam logic [LIM_W-1:0] CUR_OVER_RST  = 16'h7fff;
  localparam logic [LIM_W-1:0] CUR_UNDER_RST = 16'h8000;
  localparam logic [LIM_W-1:0] BUS_HIGH_RST  = 16'h7fff;
  localparam logic [LIM_W-1:0] BUS_UNDER_RST = 16'h0000;
  localparam logic [LIM_W-1:0] TEMP_OVER_RST = 16'h7fff;
  localparam logic [LIM_W-1:0] PWR_OVER_RST  = 16'hffff;
  localparam logic [5:0]       ENA_RST       = 6'h3f;
  // Alert source bit positions
  localparam int A_CUR_OVER  = 0;
  localparam int A_CUR_UNDER = 1;
  localparam int A_BUS_HIGH  = 2;
  localparam int A_BUS_UNDER = 3;
  localparam int A_TEMP_OVER = 4;
  localparam int A_PWR_OVER  = 5;
  // Converter channel sequence
  typedef enum logic [1:0] {
    PMLA_CH_TEMP = 2'b00,
    PMLA_CH_CUR  = 2'b01,
    PMLA_CH_VBUS = 2'b10,
    PMLA_CH_MATH = 2'b11
  } pmla_chan_t;
endpackage

// ### tb/pmla_host_model.sv
// Host side model that programs thresholds and alert enables
`timescale 1ns/100ps
module pmla_host_model (
  // Clock
  input  wire logic        mclk,
  // Threshold and enable writes
  output logic             limWrite,
  output logic [2:0]       limSel,
  output logic [15:0]      limData,
  output logic [5:0]       alertEnable,
  output logic             alertEnableWrite
);
  // Idle values at time zero
  initial {limWrite, limSel, limData, alertEnable, alertEnableWrite} = '0;
  // One write strobe, launched and dropped on falling edges
  task automatic put(input logic en, input logic [2:0] s, input logic [15:0] d);
    @(negedge mclk);
    limSel = s;
    limData = d;
    alertEnable = d[5:0];
    limWrite = !en;
    alertEnableWrite = en;
    @(negedge mclk);
    limWrite = 1'b0;
    alertEnableWrite = 1'b0;
    limData = ~d; // Released data no longer shows the value
  endtask
endmodule // pmla_host_model

// ### tb/pmla_limit_alert_props.sv
// Checker of result and alert timing at the limit and alert block ports
`timescale 1ns/100ps
module pmla_limit_alert_props #(
  parameter int CONV_CYC = 8,
  parameter int MATH_CYC = 4
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        convRun,
  input wire logic [15:0] tempResult,
  input wire logic [15:0] curResult,
  input wire logic [15:0] vbusResult,
  input wire logic [23:0] powerResult,
  input wire logic        resultValid,
  input wire logic [5:0]  alertFlags,
  input wire logic        alertOut
);
  localparam int VQ = MATH_CYC;
  localparam int CQ = CONV_CYC + MATH_CYC;
  localparam int TQ = 2 * CONV_CYC + MATH_CYC;
  localparam int PER = 3 * CONV_CYC + MATH_CYC;
  localparam int FIRST = PER + 4;
  // Magnitude of the current code
  logic [15:0] absCur;
  assign absCur = curResult[15] ? 16'h0000 - curResult : curResult;
  default clocking cb @(posedge mclk);
  endclocking
  // Stopped converter has no slot timing to check
  default disable iff (sys_rst || !convRun);
  bus_positive_a: assert property (vbusResult[15] == 1'b0)
    else $error("bus voltage result negative");
  alert_or_a: assert property (alertOut == |alertFlags)
    else $error("alert output differs from flags");
  first_result_a: assert property ($fell(sys_rst) |-> ##[1:FIRST] resultValid)
    else $error("no result after reset");
  cycle_period_a: assert property (resultValid |=> !resultValid ##(PER-1) resultValid)
    else $error("conversion cycle length wrong");
  power_math_a: assert property (resultValid |->
    powerResult == 24'((32'(absCur) * 32'(vbusResult)) >> 8))
    else $error("power result wrong");
  power_update_a: assert property ($changed(powerResult) || $changed(alertFlags[5])
    |-> resultValid)
    else $error("power changed outside math end");
  bus_slot_a: assert property ($changed(vbusResult) || $changed(alertFlags[3:2])
    |-> ##VQ resultValid)
    else $error("bus update out of slot");
  cur_slot_a: assert property ($changed(curResult) || $changed(alertFlags[1:0])
    |-> ##CQ resultValid)
    else $error("current update out of slot");
  temp_slot_a: assert property ($changed(tempResult) || $changed(alertFlags[4])
    |-> ##TQ resultValid)
    else $error("temperature update out of slot");
endmodule // pmla_limit_alert_props
bind pmla_limit_alert pmla_limit_alert_props #(.CONV_CYC(CONV_CYC), .MATH_CYC(MATH_CYC)) props (
  .mclk(mclk), .sys_rst(sys_rst), .tempResult(tempResult), .curResult(curResult),
  .vbusResult(vbusResult), .powerResult(powerResult), .resultValid(resultValid),
  .alertFlags(alertFlags), .alertOut(alertOut), .convRun(convRun));

// ### tb/test_power_monitor_limit_alert.sv
// Testbench of the limit and alert block
`timescale 1ns/100ps
module test_power_monitor_limit_alert;
  logic        mclk, sys_rst, convRun, limWrite, alertEnableWrite, resultValid, alertOut;
  logic [15:0] tempSample, curSample, vbusSample, limData, tempResult, curResult, vbusResult;
  logic [2:0]  limSel;
  logic [5:0]  alertEnable, alertFlags;
  logic [23:0] powerResult;
  int          fail_count, n_tests;
  int          cycles = 0;
  pmla_limit_alert #(.CONV_CYC(8), .MATH_CYC(4)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .convRun(convRun), .tempSample(tempSample), .curSample(curSample),
    .vbusSample(vbusSample), .limWrite(limWrite), .limSel(limSel), .limData(limData),
    .alertEnable(alertEnable), .alertEnableWrite(alertEnableWrite),
    .tempResult(tempResult), .curResult(curResult), .vbusResult(vbusResult),
    .powerResult(powerResult), .resultValid(resultValid), .alertFlags(alertFlags),
    .alertOut(alertOut));
  pmla_host_model host (.mclk(mclk), .limWrite(limWrite), .limSel(limSel),
    .limData(limData), .alertEnable(alertEnable), .alertEnableWrite(alertEnableWrite));
  // Clock of 4 ns
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count = fail_count + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Two result pulses, so a whole cycle sees the new samples
  task automatic settle();
    repeat (2)
    begin
      @(negedge mclk);
      while (resultValid !== 1'b1)
        @(negedge mclk);
    end
  endtask
  task automatic t_defaults();
    chk("flags at reset", 24'(alertFlags), 24'h0);
    {tempSample, curSample, vbusSample} = {3{16'h7fff}};
    settle();
    chk("flags at defaults", 24'(alertFlags), 24'h0);
    chk("power", powerResult, 24'h3fff00);
    $display("test defaults done");
  endtask
  task automatic t_current();
    host.put(1'b0, 3'h0, 16'h445c);
    curSample = 16'h445c;
    settle();
    chk("flags at limit", 24'(alertFlags), 24'h0);
    curSample = 16'h445d;
    settle();
    chk("alert over", 24'({alertOut, alertFlags}), 24'h41);
    host.put(1'b1, 3'h0, 16'h003e);
    settle();
    chk("alert masked", 24'(alertOut), 24'h0);
    host.put(1'b1, 3'h0, 16'h003f);
    $display("test current done");
  endtask
  task automatic t_bus_power();
    host.put(1'b0, 3'h2, 16'h4380);
    curSample = 16'h3a98;
    vbusSample = 16'hc381;
    settle();
    chk("bus result", 24'(vbusResult), 24'h4381);
    chk("bus flags", 24'(alertFlags), 24'h04);
    vbusSample = 16'h3c00;
    host.put(1'b0, 3'h5, 16'h0dbb);
    settle();
    chk("power at limit", powerResult, 24'h0dbba0);
    chk("flags at power limit", 24'(alertFlags), 24'h0);
    host.put(1'b0, 3'h5, 16'h0dba);
    settle();
    chk("power over", 24'(alertFlags), 24'h20);
    $display("test bus power done");
  endtask
  task automatic t_negative();
    host.put(1'b0, 3'h1, 16'h0000);
    curSample = 16'hffff;
    settle();
    chk("negative current", 24'(curResult), 24'h00ffff);
    chk("under flag", 24'(alertFlags), 24'h02);
    $display("test negative done");
  endtask
  task automatic t_latency();
    int k;
    for (int i = 0; i < 28; i += 3)
    begin
      curSample = 16'h0000;
      settle();
      repeat (i) @(negedge mclk);
      curSample = 16'h445d;
      k = 0;
      while (alertOut !== 1'b1 && k < 60)
      begin
        @(negedge mclk);
        k = k + 1;
      end
      chk("latency bound", 24'(k >= 2 && k <= 36), 24'h1);
    end
    $display("test latency done");
  endtask
  task automatic t_rerun();
    host.put(1'b1, 3'h0, 16'h0000);
    sys_rst = 1'b1;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    chk("alert in reset", 24'(alertOut), 24'h0);
    settle();
    chk("flags after reset", 24'(alertFlags), 24'h0);
    host.put(1'b0, 3'h0, 16'h0000);
    settle();
    chk("enables after reset", 24'(alertFlags), 24'h01);
    $display("test rerun done");
  endtask
  // Stopped converter holds flags; select 6 writes nothing
  task automatic t_hold();
    int seen;
    seen = 0;
    convRun = 1'b0;
    host.put(1'b0, 3'h6, 16'h0000);
    repeat (40)
    begin
      @(negedge mclk);
      if (resultValid === 1'b1)
        seen = seen + 1;
    end
    chk("pulses while stopped", 24'(seen), 24'h0);
    chk("flags held", 24'(alertFlags), 24'h01);
    convRun = 1'b1;
    settle();
    chk("ignored select", 24'(alertFlags), 24'h01);
    $display("test hold done");
  endtask
  initial
  begin
    {sys_rst, convRun, fail_count, n_tests} = {2'b11, 64'h0};
    {tempSample, curSample, vbusSample} = '0;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    t_defaults();
    t_current();
    t_bus_power();
    t_negative();
    t_latency();
    t_rerun();
    t_hold();
    close_out();
  end
endmodule // test_power_monitor_limit_alert

// ### verilog/pmla_conv_seq.sv
// Converter sequencer: temperature, current, bus voltage, then background math
`timescale 1ns/100ps
module pmla_conv_seq #(
  parameter int CONV_CYC = pmla_pkg::CONV_CYCLES,
  parameter int MATH_CYC = pmla_pkg::MATH_CYCLES
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // Control
  input  wire logic                   convRun,
  // Sequence status
  output pmla_pkg::pmla_chan_t        chan,
  output logic                        chanDone
);
  localparam int CW = pmla_pkg::CNT_W;
  logic [CW-1:0] tick;
  logic [CW-1:0] limit;

  // Current slot length
  always_comb
  begin
    if (chan == pmla_pkg::PMLA_CH_MATH)
      limit = CW'(MATH_CYC - 1);
    else
      limit = CW'(CONV_CYC - 1);
  end

  // Free-running sequential conversion slots
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick     <= '0;
      chan     <= pmla_pkg::PMLA_CH_TEMP;
      chanDone <= 1'b0;
    end
    else if (!convRun)
    begin
      tick     <= '0;
      chan     <= pmla_pkg::PMLA_CH_TEMP;
      chanDone <= 1'b0;
    end
    else if (tick == limit)
    begin
      tick     <= '0;
      chanDone <= 1'b1;
      case (chan)
        pmla_pkg::PMLA_CH_TEMP: chan <= pmla_pkg::PMLA_CH_CUR;
        pmla_pkg::PMLA_CH_CUR:  chan <= pmla_pkg::PMLA_CH_VBUS;
        pmla_pkg::PMLA_CH_VBUS: chan <= pmla_pkg::PMLA_CH_MATH;
        default:                chan <= pmla_pkg::PMLA_CH_TEMP;
      endcase
    end
    else
    begin
      tick     <= tick + 1'b1;
      chanDone <= 1'b0;
    end
  end
endmodule // pmla_conv_seq

// ### verilog/pmla_limit_alert.sv
// Power monitor result capture, limit comparison and alert output
`timescale 1ns/100ps
module pmla_limit_alert #(
  parameter int CONV_CYC = pmla_pkg::CONV_CYCLES,
  parameter int MATH_CYC = pmla_pkg::MATH_CYCLES
) (
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             sys_rst,
  // Converter control
  input  wire logic                             convRun,
  // Raw samples from the analog front end, outside this clock domain
  input  wire logic [pmla_pkg::RES_W-1:0]       tempSample,
  input  wire logic [pmla_pkg::RES_W-1:0]       curSample,
  input  wire logic [pmla_pkg::RES_W-1:0]       vbusSample,
  // Thresholds and alert enables, written by the serial port logic
  input  wire logic                             limWrite,
  input  wire logic [2:0]                       limSel,
  input  wire logic [pmla_pkg::LIM_W-1:0]       limData,
  input  wire logic [5:0]                       alertEnable,
  input  wire logic                             alertEnableWrite,
  // Results
  output logic [pmla_pkg::RES_W-1:0]            tempResult,
  output logic [pmla_pkg::RES_W-1:0]            curResult,
  output logic [pmla_pkg::RES_W-1:0]            vbusResult,
  output logic [pmla_pkg::PWR_W-1:0]            powerResult,
  output logic                                  resultValid,
  // Alert status
  output logic [5:0]                            alertFlags,
  output logic                                  alertOut
);
  pmla_pkg::pmla_chan_t              chan;
  logic                              chanDone;
  logic [pmla_pkg::RES_W-1:0]        tempS1, tempS2, curS1, curS2, vbusS1, vbusS2;
  logic [pmla_pkg::LIM_W-1:0]        currentOverLimit;
  logic [pmla_pkg::LIM_W-1:0]        currentUnderLimit;
  logic [pmla_pkg::LIM_W-1:0]        bus_high_voltage_limit;
  logic [pmla_pkg::LIM_W-1:0]        busUnderLimit;
  logic [pmla_pkg::LIM_W-1:0]        tempOverLimit;
  logic [pmla_pkg::LIM_W-1:0]        powerOverLimit;
  logic [5:0]                        enables;
  logic [5:0]                        next_alertFlags;
  logic [31:0]                       prodMag;

  // Signed greater-than on two's complement codes
  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  // Magnitude of a two's complement code
  function automatic logic [15:0] smag(input logic [15:0] a);
    smag = a[15] ? 16'(~a + 16'h0001) : a;
  endfunction

  // Sequential conversion slots
  pmla_conv_seq #(
    .CONV_CYC (CONV_CYC),
    .MATH_CYC (MATH_CYC)
  ) u_seq (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .convRun  (convRun),
    .chan     (chan),
    .chanDone (chanDone)
  );

  // Two-stage synchronisers on front-end samples
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tempS1 <= '0;
      tempS2 <= '0;
      curS1  <= '0;
      curS2  <= '0;
      vbusS1 <= '0;
      vbusS2 <= '0;
    end
    else
    begin
      tempS1 <= tempSample;
      tempS2 <= tempS1;
      curS1  <= curSample;
      curS2  <= curS1;
      vbusS1 <= vbusSample;
      vbusS2 <= vbusS1;
    end
  end

  // Threshold registers, defaults on every reset
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      currentOverLimit       <= pmla_pkg::CUR_OVER_RST;
      currentUnderLimit      <= pmla_pkg::CUR_UNDER_RST;
      bus_high_voltage_limit <= pmla_pkg::BUS_HIGH_RST;
      busUnderLimit          <= pmla_pkg::BUS_UNDER_RST;
      tempOverLimit          <= pmla_pkg::TEMP_OVER_RST;
      powerOverLimit         <= pmla_pkg::PWR_OVER_RST;
    end
    else if (limWrite)
    begin
      case (limSel)
        3'h0:    currentOverLimit       <= limData;
        3'h1:    currentUnderLimit      <= limData;
        3'h2:    bus_high_voltage_limit <= limData;
        3'h3:    busUnderLimit          <= limData;
        3'h4:    tempOverLimit          <= limData;
        3'h5:    powerOverLimit         <= limData;
        default: ;
      endcase
    end
  end

  // Alert enables, defaults on every reset
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      enables <= pmla_pkg::ENA_RST;
    else if (alertEnableWrite)
      enables <= alertEnable;
  end

  // Power magnitude from current and bus voltage codes
  assign prodMag = smag(curResult) * vbusResult;

  // Result capture at the end of each channel slot
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tempResult  <= '0;
      curResult   <= '0;
      vbusResult  <= '0;
      powerResult <= '0;
      resultValid <= 1'b0;
    end
    else
    begin
      resultValid <= 1'b0;
      if (chanDone)
      begin
        case (chan)
          pmla_pkg::PMLA_CH_CUR:  tempResult <= tempS2;
          pmla_pkg::PMLA_CH_VBUS: curResult  <= curS2;
          pmla_pkg::PMLA_CH_MATH: vbusResult <= {1'b0, vbusS2[14:0]};
          default:
          begin
            powerResult <= prodMag[pmla_pkg::PWR_W+7:8];
            resultValid <= 1'b1;
          end
        endcase
      end
    end
  end

  // Limit comparison on fresh results only
  always_comb
  begin
    next_alertFlags = alertFlags;
    if (chanDone)
    begin
      case (chan)
        pmla_pkg::PMLA_CH_VBUS:
        begin
          next_alertFlags[pmla_pkg::A_CUR_OVER] = enables[pmla_pkg::A_CUR_OVER]
            && sgt(curS2, currentOverLimit);
          next_alertFlags[pmla_pkg::A_CUR_UNDER] = enables[pmla_pkg::A_CUR_UNDER]
            && sgt(currentUnderLimit, curS2);
        end
        pmla_pkg::PMLA_CH_MATH:
        begin
          next_alertFlags[pmla_pkg::A_BUS_HIGH] = enables[pmla_pkg::A_BUS_HIGH]
            && (vbusS2[14:0] > bus_high_voltage_limit[14:0]);
          next_alertFlags[pmla_pkg::A_BUS_UNDER] = enables[pmla_pkg::A_BUS_UNDER]
            && (vbusS2[14:0] < busUnderLimit[14:0]);
        end
        pmla_pkg::PMLA_CH_CUR:
          next_alertFlags[pmla_pkg::A_TEMP_OVER] = enables[pmla_pkg::A_TEMP_OVER]
            && sgt(tempS2, tempOverLimit);
        default:
          next_alertFlags[pmla_pkg::A_PWR_OVER] = enables[pmla_pkg::A_PWR_OVER]
            && (prodMag[pmla_pkg::PWR_W+7:pmla_pkg::PWR_SHIFT+8]
                > powerOverLimit);
      endcase
    end
  end

  // Alert flags and pin, updated once per completed result
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      alertFlags <= '0;
      alertOut   <= 1'b0;
    end
    else
    begin
      alertFlags <= next_alertFlags;
      alertOut   <= |next_alertFlags;
    end
  end
endmodule // pmla_limit_alert
